// ===== rtl/tvm_defines.svh
`ifndef TVM_DEFINES_SVH
`define TVM_DEFINES_SVH
// register indices on the register port
`define TVM_ADDR_MODE 8'h00
`define TVM_ADDR_FLICKER 8'h01
`define TVM_ADDR_BANDWIDTH 8'h02
// reset values
`define TVM_RST_MODE 8'h6A
`define TVM_RST_FLICKER 8'h27
`define TVM_RST_BANDWIDTH 8'h1E
// flicker register write mask, reserved top bit dropped
`define TVM_FLICKER_MASK 8'h7F
// dot crawl setting
`define TVM_DOT_CRAWL 2'h3
// mode count
`define TVM_MODES 6'h27
`define TVM_BAD_MODE 6'h3F
`endif

// ===== rtl/tvm_pkg.sv
package tvm_pkg;
   typedef enum logic [1:0] {
      TVM_PAL = 2'b00,
      TVM_NTSC = 2'b01,
      TVM_PALM = 2'b10,
      TVM_NTSCJ = 2'b11
   } tvm_std_t;
   typedef enum logic [2:0] {
      TVM_R54 = 3'b000,
      TVM_R11 = 3'b001,
      TVM_R58 = 3'b010,
      TVM_R59 = 3'b011,
      TVM_R12 = 3'b100
   } tvm_ratio_t;
   typedef struct packed {
      logic [5:0] modeIndex;
      logic modeValid;
      logic [10:0] totalPixels;
      logic [10:0] totalLines;
      logic [27:0] pixelClockHz;
      tvm_ratio_t ratio;
   } tvm_timing_t;
   typedef struct packed {
      logic [2:0] lumaNonTextLines;
      logic [2:0] lumaTextLines;
      logic [2:0] chromaLines;
      logic dotCrawlOn;
      logic rgbOut;
      logic [1:0] compositeLumaBw;
      logic [1:0] svideoLumaBw;
      logic chromaBw;
      logic compositeMono;
      logic subcarrierLock;
      logic blankingDefeat;
   } tvm_filter_t;
endpackage

// ===== rtl/tvm_mode_decode.sv
`timescale 1ns/1ps
`include "tvm_defines.svh"
module tvm_mode_decode (
   // mode fields
   input wire logic [7:0] modeCode,
   // decoded timing
   output tvm_pkg::tvm_timing_t timing
);
   import tvm_pkg::*;
   typedef struct packed {
      logic [7:0] code;
      logic [10:0] px;
      logic [10:0] ln;
      logic [27:0] hz;
      tvm_ratio_t r;
   } tvm_row_t;
   localparam tvm_row_t TBL [0:38] = '{
      '{8'h00, 11'd840, 11'd500, 28'd21000000, TVM_R54},
      '{8'h01, 11'd840, 11'd625, 28'd26250000, TVM_R11},
      '{8'h08, 11'd800, 11'd420, 28'd20139860, TVM_R54},
      '{8'h09, 11'd784, 11'd525, 28'd24671329, TVM_R11},
      '{8'h20, 11'd1125, 11'd500, 28'd28125000, TVM_R54},
      '{8'h21, 11'd1152, 11'd625, 28'd36000000, TVM_R11},
      '{8'h28, 11'd945, 11'd420, 28'd23790210, TVM_R54},
      '{8'h29, 11'd936, 11'd525, 28'd29454545, TVM_R11},
      '{8'h40, 11'd1000, 11'd500, 28'd25000000, TVM_R54},
      '{8'h41, 11'd1008, 11'd625, 28'd31500000, TVM_R11},
      '{8'h48, 11'd840, 11'd420, 28'd21146854, TVM_R54},
      '{8'h49, 11'd832, 11'd525, 28'd26181819, TVM_R11},
      '{8'h4A, 11'd840, 11'd600, 28'd30209791, TVM_R11},
      '{8'h60, 11'd840, 11'd500, 28'd21000000, TVM_R54},
      '{8'h61, 11'd840, 11'd625, 28'd26250000, TVM_R11},
      '{8'h63, 11'd840, 11'd750, 28'd31500000, TVM_R11},
      '{8'h69, 11'd784, 11'd525, 28'd24671329, TVM_R11},
      '{8'h6A, 11'd784, 11'd600, 28'd28195805, TVM_R11},
      '{8'h6B, 11'd800, 11'd630, 28'd30209790, TVM_R11},
      '{8'h89, 11'd882, 11'd525, 28'd27755245, TVM_R11},
      '{8'h8A, 11'd882, 11'd600, 28'd31720280, TVM_R11},
      '{8'h8B, 11'd900, 11'd630, 28'd33986015, TVM_R11},
      '{8'hA1, 11'd882, 11'd625, 28'd27562500, TVM_R11},
      '{8'hA3, 11'd900, 11'd750, 28'd33750000, TVM_R11},
      '{8'hA4, 11'd900, 11'd875, 28'd39375000, TVM_R11},
      '{8'hC1, 11'd944, 11'd625, 28'd29500000, TVM_R11},
      '{8'hC3, 11'd960, 11'd750, 28'd36000000, TVM_R11},
      '{8'hC4, 11'd960, 11'd875, 28'd42000000, TVM_R11},
      '{8'hCE, 11'd1040, 11'd700, 28'd43636364, TVM_R11},
      '{8'hCF, 11'd1064, 11'd750, 28'd47832169, TVM_R11},
      '{8'hCD, 11'd1040, 11'd840, 28'd52363637, TVM_R58},
      '{8'hE4, 11'd1400, 11'd875, 28'd61250000, TVM_R11},
      '{8'hE5, 11'd1400, 11'd1000, 28'd70000000, TVM_R58},
      '{8'hE6, 11'd1400, 11'd1125, 28'd78750000, TVM_R59},
      '{8'hED, 11'd1160, 11'd840, 28'd58405595, TVM_R58},
      '{8'hEE, 11'd1160, 11'd945, 28'd65706295, TVM_R59},
      '{8'hEF, 11'd1168, 11'd1050, 28'd73510491, TVM_R12},
      '{8'hA0, 11'd864, 11'd625, 28'd13500000, TVM_R11},
      '{8'h88, 11'd858, 11'd525, 28'd13500000, TVM_R11}
   };
   // table search; standards 10 and 11 reuse the NTSC rows
   logic [7:0] keyCode;
   // standard 1x folds onto the 01 rows
   assign keyCode = modeCode[4] ? {modeCode[7:5], 2'b01, modeCode[2:0]} : modeCode;
   always_comb begin
      timing = '0;
      timing.modeIndex = `TVM_BAD_MODE;
      timing.ratio = TVM_R11;
      for (int i = 0; i < int'(`TVM_MODES); i++) begin
         if (TBL[i].code == keyCode) begin
            timing.modeIndex = 6'(i);
            timing.modeValid = 1'b1;
            timing.totalPixels = TBL[i].px;
            timing.totalLines = TBL[i].ln;
            timing.pixelClockHz = TBL[i].hz;
            timing.ratio = TBL[i].r;
         end
      end
   end
endmodule // tvm_mode_decode

// ===== rtl/tvm_mode_filter_control.sv
// What this block does
// - decode mode fields; code 000/00/000 gives 840x500 PAL at 21 MHz
// - code 111/01/111 gives 1168x1050 NTSC, 1/2 scaling, 73.510491 MHz
// - 101/00/000 gives 864x625, 100/01/000 gives 858x525, both 13.5 MHz
// - standard field: 00 PAL, 01 NTSC, 10 PAL-M, 11 NTSC-J
// - flicker bits 1-0 pick luma non-text filter
// - flicker bits 3-2 pick luma text filter
// - luma filter depth follows the ratio table per setting
// - flicker bits 5-4 pick chroma filter
// - chroma setting 11 turns on dot crawl reduction
// - chroma depth equals luma depth, except ratio 5/8 setting 11 gives 5
// - flicker bit 6: 0 composite and S-Video, 1 RGB
// - bandwidth bits 1-0 pick composite luma bandwidth
// - bandwidth bits 3-2 pick S-Video luma bandwidth
// - mode register: resolution 7-5, standard 4-3, scaling 2-0, all writable
// - bandwidth bit 4 picks chroma bandwidth
// - bandwidth bit 5 low puts S-Video luma on composite pin too
`timescale 1ns/1ps
`include "tvm_defines.svh"
module tvm_mode_filter_control (
   // clock and control
   input wire logic mclk,
   input wire logic rst,
   input wire logic clkEn,
   // register port, same clock
   input wire logic regWrite,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regAddrHit,
   // decoded outputs
   output tvm_pkg::tvm_timing_t timing,
   output tvm_pkg::tvm_std_t outputStandard,
   output tvm_pkg::tvm_filter_t filterCfg
);
   import tvm_pkg::*;
   logic [7:0] displayModeReg_r, displayModeReg_nxt;
   logic [7:0] flickerFilterReg_r, flickerFilterReg_nxt;
   logic [7:0] videoBandwidthReg_r, videoBandwidthReg_nxt;
   tvm_timing_t timingNow;
   tvm_filter_t filterNow;
   wire hitMode;
   wire hitFlicker;
   wire hitBandwidth;

   // address decode
   assign hitMode = regAddr == `TVM_ADDR_MODE;
   assign hitFlicker = regAddr == `TVM_ADDR_FLICKER;
   assign hitBandwidth = regAddr == `TVM_ADDR_BANDWIDTH;
   assign regAddrHit = hitMode | hitFlicker | hitBandwidth;

   // next register values
   // mode register write
   assign displayModeReg_nxt = (regWrite && hitMode) ? regWrData : displayModeReg_r;
   assign flickerFilterReg_nxt = (regWrite && hitFlicker) ? (regWrData & `TVM_FLICKER_MASK)
                                                          : flickerFilterReg_r;
   assign videoBandwidthReg_nxt = (regWrite && hitBandwidth) ? regWrData
                                                             : videoBandwidthReg_r;

   // register store
   always_ff @(posedge mclk) begin
      if (rst) begin
         displayModeReg_r <= `TVM_RST_MODE;
         flickerFilterReg_r <= `TVM_RST_FLICKER;
         videoBandwidthReg_r <= `TVM_RST_BANDWIDTH;
      end else if (clkEn) begin
         displayModeReg_r <= displayModeReg_nxt;
         flickerFilterReg_r <= flickerFilterReg_nxt;
         videoBandwidthReg_r <= videoBandwidthReg_nxt;
      end
   end

   // read mux, unmapped reads zero
   assign regRdData = hitMode ? displayModeReg_r :
                      hitFlicker ? flickerFilterReg_r :
                      hitBandwidth ? videoBandwidthReg_r : 8'h00;

   tvm_mode_decode uDecode (
      .modeCode(displayModeReg_r),
      .timing(timingNow)
   );

   // depth per ratio and setting
   function automatic logic [2:0] lumaDepth(input tvm_ratio_t r, input logic [1:0] s);
      logic [11:0] row;
      row = 12'h000;
      case (r)
         TVM_R54: row = {3'd3, 3'd3, 3'd3, 3'd2};
         TVM_R11: row = {3'd5, 3'd4, 3'd3, 3'd2};
         TVM_R58: row = {3'd6, 3'd4, 3'd3, 3'd2};
         TVM_R59: row = {3'd6, 3'd5, 3'd4, 3'd3};
         TVM_R12: row = {3'd7, 3'd5, 3'd5, 3'd3};
         default: row = {3'd5, 3'd4, 3'd3, 3'd2};
      endcase
      lumaDepth = row[s*3 +: 3];
   endfunction

   // filter configuration decode
   always_comb begin
      filterNow = '0;
      filterNow.lumaNonTextLines = lumaDepth(timingNow.ratio, flickerFilterReg_r[1:0]);
      filterNow.lumaTextLines = lumaDepth(timingNow.ratio, flickerFilterReg_r[3:2]);
      if (timingNow.ratio == TVM_R58 && flickerFilterReg_r[5:4] == `TVM_DOT_CRAWL)
         filterNow.chromaLines = 3'd5;
      else
         filterNow.chromaLines = lumaDepth(timingNow.ratio, flickerFilterReg_r[5:4]);
      filterNow.dotCrawlOn = flickerFilterReg_r[5:4] == `TVM_DOT_CRAWL;
      filterNow.rgbOut = flickerFilterReg_r[6];
      filterNow.compositeLumaBw = videoBandwidthReg_r[1:0];
      filterNow.svideoLumaBw = videoBandwidthReg_r[3:2];
      filterNow.chromaBw = videoBandwidthReg_r[4];
      filterNow.compositeMono = ~videoBandwidthReg_r[5];
      filterNow.subcarrierLock = videoBandwidthReg_r[6];
      filterNow.blankingDefeat = videoBandwidthReg_r[7];
   end

   // registered outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         timing <= '0;
         outputStandard <= TVM_PAL;
         filterCfg <= '0;
      end else if (clkEn) begin
         timing <= timingNow;
         outputStandard <= tvm_std_t'(displayModeReg_r[4:3]);
         filterCfg <= filterNow;
      end
   end

   // checks
   logic pastValid_r;
   always_ff @(posedge mclk) begin
      if (rst) pastValid_r <= 1'b0;
      else if (clkEn) pastValid_r <= 1'b1;
   end

   mode_zero_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && displayModeReg_r == 8'h00 |=> timing.totalPixels == 11'd840
      && timing.totalLines == 11'd500 && timing.pixelClockHz == 28'd21000000)
      else $error("mode 0 timing wrong");
   mode_half_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && displayModeReg_r == 8'hEF |=> timing.totalLines == 11'd1050
      && timing.ratio == TVM_R12 && timing.pixelClockHz == 28'd73510491)
      else $error("mode 36 timing wrong");
   mode_sd_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && displayModeReg_r == 8'hA0 |=> timing.totalPixels == 11'd864
      && timing.totalLines == 11'd625 && timing.pixelClockHz == 28'd13500000)
      else $error("mode 37 timing wrong");
   std_sel_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn |=> outputStandard == $past(displayModeReg_r[4:3]))
      else $error("standard select wrong");
   crawl_depth_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && timingNow.ratio == TVM_R58 && flickerFilterReg_r[5:4] == 2'b11
      |=> filterCfg.chromaLines == 3'd5 && filterCfg.lumaNonTextLines <= 3'd6)
      else $error("5/8 chroma depth wrong");
   half_depth_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && timingNow.ratio == TVM_R12 && flickerFilterReg_r[1:0] == 2'b11
      |=> filterCfg.lumaNonTextLines == 3'd7)
      else $error("1/2 luma depth wrong");
   rgb_sel_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn |=> filterCfg.rgbOut == $past(flickerFilterReg_r[6]))
      else $error("output format wrong");
   mono_sel_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn |=> filterCfg.compositeMono == !$past(videoBandwidthReg_r[5]))
      else $error("mono composite wrong");
   ff_reserved_a: assert property (@(posedge mclk) disable iff (rst)
      regWrite && hitFlicker && clkEn |=> flickerFilterReg_r[7] == 1'b0
      && flickerFilterReg_r[6:0] == $past(regWrData[6:0]))
      else $error("flicker write wrong");
   mode_write_a: assert property (@(posedge mclk) disable iff (rst)
      regWrite && hitMode && clkEn |=> displayModeReg_r == $past(regWrData))
      else $error("mode write wrong");

   mode_write_c: cover property (@(posedge mclk) disable iff (rst)
      regWrite && hitMode && clkEn);
   crawl_c: cover property (@(posedge mclk) disable iff (rst) filterCfg.dotCrawlOn);
   rgb_c: cover property (@(posedge mclk) disable iff (rst) filterCfg.rgbOut);
   bad_mode_c: cover property (@(posedge mclk) disable iff (rst)
      pastValid_r && !timing.modeValid);
endmodule // tvm_mode_filter_control

// ===== test/test_tv_mode_filter_control.sv
`timescale 1ns/1ps
module test_tv_mode_filter_control;
   import tvm_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   logic regWrite = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData;
   logic regAddrHit;
   tvm_timing_t timing;
   tvm_std_t outputStandard;
   tvm_filter_t filterCfg;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [7:0] flickVal = 8'h27;
   logic [7:0] bandVal = 8'h1E;
   logic [60:0] row;
   // only listed mode combinations are programmed
   // mode code, total pixels, total lines, pixel clock in Hz, ratio group
   localparam logic [60:0] MODES [9] = '{
      {8'h00, 11'd840, 11'd500, 28'd21000000, 3'h0},
      {8'hEF, 11'd1168, 11'd1050, 28'd73510491, 3'h4},
      {8'hA0, 11'd864, 11'd625, 28'd13500000, 3'h1},
      {8'h88, 11'd858, 11'd525, 28'd13500000, 3'h1},
      {8'hED, 11'd1160, 11'd840, 28'd58405595, 3'h2},
      {8'hE6, 11'd1400, 11'd1125, 28'd78750000, 3'h3},
      {8'hE4, 11'd1400, 11'd875, 28'd61250000, 3'h1},
      {8'hF7, 11'd1168, 11'd1050, 28'd73510491, 3'h4},
      {8'hFF, 11'd1168, 11'd1050, 28'd73510491, 3'h4}};
   // table row that each of those codes lands on
   localparam logic [5:0] MODE_ROW [9] = '{6'h00, 6'h24, 6'h25, 6'h26, 6'h22, 6'h21, 6'h1F,
                                           6'h24, 6'h24};

   tvm_mode_filter_control u_dut (
      .mclk(mclk),
      .rst(rst),
      .clkEn(clkEn),
      .regWrite(regWrite),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regRdData(regRdData),
      .regAddrHit(regAddrHit),
      .timing(timing),
      .outputStandard(outputStandard),
      .filterCfg(filterCfg)
   );

   // free running clock, 100 ns period
   always #50 mclk = ~mclk;

   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 20000) begin
         err_total++;
         stop_test();
      end
   end

   // luma depth per ratio group and setting
   function automatic logic [2:0] lumaD(input logic [2:0] r, input logic [1:0] s);
      case (r)
         3'h0: lumaD = (s == 2'h0) ? 3'h2 : 3'h3;
         3'h2: lumaD = (s == 2'h3) ? 3'h6 : 3'(s) + 3'h2;
         3'h3: lumaD = 3'(s) + 3'h3;
         3'h4: lumaD = (s == 2'h0) ? 3'h3 : ((s == 2'h3) ? 3'h7 : 3'h5);
         default: lumaD = 3'(s) + 3'h2;
      endcase
   endfunction

   // chroma depth, 5/8 at the top setting is one line short
   function automatic logic [2:0] chromaD(input logic [2:0] r, input logic [1:0] s);
      chromaD = (r == 3'h2 && s == 2'h3) ? 3'h5 : lumaD(r, s);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one write strobe, then wait until the outputs follow
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      regWrite = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge mclk);
      regWrite = 1'b0;
      @(negedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      regAddr = a;
      #1;
      chk(32'(regRdData), 32'(exp));
      chk(32'(regAddrHit), 32'(hit));
   endtask

   task automatic chkF(input logic [2:0] r);
      chk(32'(filterCfg.lumaNonTextLines), 32'(lumaD(r, flickVal[1:0])));
      chk(32'(filterCfg.lumaTextLines), 32'(lumaD(r, flickVal[3:2])));
      chk(32'(filterCfg.chromaLines), 32'(chromaD(r, flickVal[5:4])));
      chk(32'(filterCfg.dotCrawlOn), 32'(flickVal[5:4] == 2'h3));
      chk(32'(filterCfg.rgbOut), 32'(flickVal[6]));
      chk(32'(filterCfg.compositeLumaBw), 32'(bandVal[1:0]));
      chk(32'(filterCfg.svideoLumaBw), 32'(bandVal[3:2]));
      chk(32'(filterCfg.chromaBw), 32'(bandVal[4]));
      chk(32'(filterCfg.compositeMono), 32'(!bandVal[5]));
      chk(32'({filterCfg.blankingDefeat, filterCfg.subcarrierLock}), 32'(bandVal[7:6]));
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // main sequence
   initial begin
      void'($urandom(1));
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      // reset contents, unmapped read gives zero
      rd(8'h00, 8'h6A, 1'b1);
      rd(8'h01, 8'h27, 1'b1);
      rd(8'h02, 8'h1E, 1'b1);
      rd(8'h03, 8'h00, 1'b0);
      chk(32'({timing.totalPixels, timing.totalLines}), 32'({11'd784, 11'd600}));
      chk(32'({timing.modeValid, timing.modeIndex}), 32'({1'b1, 6'h11}));
      chk(32'(outputStandard), 32'h1);
      chkF(3'h1);
      // every listed mode in the table, random filter bytes under each
      for (int m = 0; m < 9; m++) begin
         row = MODES[m];
         wr(8'h00, row[60:53]);
         rd(8'h00, row[60:53], 1'b1);
         chk(32'({timing.modeValid, timing.totalPixels}), 32'({1'b1, row[52:42]}));
         chk(32'(timing.modeIndex), 32'(MODE_ROW[m]));
         chk(32'(timing.totalLines), 32'(row[41:31]));
         chk(32'(timing.pixelClockHz), 32'(row[30:3]));
         chk(32'(timing.ratio), 32'(row[2:0]));
         chk(32'(outputStandard), 32'(row[57:56]));
         for (int k = 0; k < 4; k++) begin
            flickVal = 8'($urandom);
            flickVal[5:4] = 2'(k);
            flickVal[1:0] = ~2'(k);
            bandVal = 8'($urandom);
            wr(8'h01, flickVal);
            flickVal[7] = 1'b0;
            wr(8'h02, bandVal);
            rd(8'h01, flickVal, 1'b1);
            rd(8'h02, bandVal, 1'b1);
            chkF(row[2:0]);
         end
      end
      // unmapped write and write while frozen leave registers alone
      wr(8'($urandom_range(255, 3)), 8'($urandom));
      clkEn = 1'b0;
      wr(8'h01, ~flickVal);
      clkEn = 1'b1;
      rd(8'h00, row[60:53], 1'b1);
      rd(8'h01, flickVal, 1'b1);
      rd(8'h02, bandVal, 1'b1);
      chkF(row[2:0]);
      stop_test();
   end
endmodule // test_tv_mode_filter_control
